// file: fpe_cfg.svh
// Register offsets, command codes, field positions and timing counts
`ifndef FPE_CFG_SVH
`define FPE_CFG_SVH
`define FPE_OFS_CMD 8'h01
`define FPE_OFS_PAGE 8'h02
`define FPE_CMD_UNLOCK1 8'h73
`define FPE_CMD_UNLOCK2 8'h8c
`define FPE_CMD_PAGE_ERASE 8'h95
`define FPE_CMD_MASS_ERASE 8'h63
`define FPE_CMD_SECT_EN 8'h5e
`define FPE_SECT_RESET 8'h00
`define FPE_PAGE_RESET 8'h00
`define FPE_INFO_PAGE3 8'h83
`define FPE_INFO_BIT 7
`define FPE_ERASED_BYTE 8'hff
`define FPE_ADDR_PAGE_HI 15
`define FPE_ADDR_PAGE_LO 9
`define FPE_SECT_SHIFT 4
`define FPE_PROG_CYC 16'h0004
`define FPE_ERASE_CYC 16'h0010
`define FPE_ICP_DONE_BIT 3
`define FPE_INFO_ADDR_HI 12
`define FPE_INFO_ADDR_LO 6
`define FPE_OPT_RESET 1'h1
`endif

// file: fpe_pkg.sv
// Types shared by the flash sequencer modules
package fpe_pkg;
  typedef enum logic [6:0] {
    FPE_LOCKED = 7'h01,
    FPE_UNL1 = 7'h02,
    FPE_UNL2 = 7'h04,
    FPE_UNL3 = 7'h08,
    FPE_OPEN = 7'h10,
    FPE_SECT = 7'h20,
    FPE_BUSY = 7'h40
  } fpe_state_t;
  typedef enum logic [1:0] {
    FPE_OP_PROG = 2'h0,
    FPE_OP_PAGE = 2'h1,
    FPE_OP_MASS = 2'h2
  } fpe_op_t;
endpackage

// file: fpe_timer_if.sv
`timescale 1ns/1ps
// Start/done link between the sequencer and its operation timer
interface fpe_timer_if;
  logic start;
  logic [15:0] cycles;
  logic done;
  modport ctl (output start, output cycles, input done);
  modport tmr (input start, input cycles, output done);
endinterface

// file: fpe_timer.sv
`timescale 1ns/1ps
// Operation duration timer: counts a loaded length, then pulses done
module fpe_timer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control link
  fpe_timer_if.tmr tif
);
  typedef struct packed {
    logic [15:0] cnt;
    logic run;
    logic done;
  } fpe_tmr_st_t;
  fpe_tmr_st_t s_r, s_nxt;
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (tif.start)
    begin
      s_nxt.cnt = tif.cycles;
      s_nxt.run = 1'b1;
    end
    else if (s_r.run)
    begin
      if (s_r.cnt <= 16'h0001)
      begin
        s_nxt.run = 1'b0;
        s_nxt.done = 1'b1;
      end
      else
        s_nxt.cnt = s_r.cnt - 16'h0001;
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
  assign tif.done = s_r.done;
endmodule // fpe_timer

// file: fpe_flash_seq.sv
`timescale 1ns/1ps
// Flash protection and program/erase sequencer
`include "fpe_cfg.svh"
// Summary of operation
// [RULE_01] Page, 73H, 8CH, same page unlocks
// [RULE_02] Other command while unlocked relocks
// [RULE_03] Program needs address 15:9 equal page
// [RULE_04] Sector is sixteen 512-byte pages
// [RULE_05] Sector guard writable only while locked
// [RULE_06] 5EH when locked redirects next 02H write
// [RULE_07] Reset clears all sector guard bits
// [RULE_08] Guard blocks CPU only, port ignores
// [RULE_09] Guard bits set only, never cleared
// [RULE_10] CPU main only; port main and info 3
// [RULE_11] Mass erase opens all; page only page (code: any page erase opens every page until another command)
// [RULE_12] Erased reads FFH; program clears bits only
// [RULE_13] Host and CPU use their write commands
// [RULE_14] CPU halted during CPU program or erase
// [RULE_15] Other command ends programming mode
// [RULE_16] Page erase FFH, CPU needs unprotected sector
// [RULE_17] 95H while unlocked starts page erase
// [RULE_18] Port erase done on status bit 3, relock (code: done is the port_done pulse; status bit 3 means byte program busy)
// [RULE_19] Info page erase needs bit 7, CPU refused
// [RULE_20] Mass erase from port only, all FFH
// [RULE_21] 63H while unlocked starts mass erase
// [RULE_22] Mass erase never touches info area
// [RULE_23] Protected info erase needs prior mass erase
// [RULE_24] Info area uses same unlock, no sectors
// [RULE_25] Sector index is page divided by sixteen
module fpe_flash_seq (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register file access (CPU or port)
  input wire logic reg_wr,
  input wire logic reg_from_port,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] status_rdata,
  output logic [7:0] page_rdata,
  output logic [7:0] guard_rdata,
  // Byte program requests
  input wire logic prog_req,
  input wire logic prog_from_port,
  input wire logic [15:0] prog_addr,
  input wire logic [7:0] prog_data,
  input wire logic [7:0] prog_old,
  // Option bits
  input wire logic protect_opt,
  // Flash array strobes
  output logic arr_prog,
  output logic [15:0] arr_addr,
  output logic [7:0] arr_data,
  output logic arr_info,
  output logic arr_page_erase,
  output logic arr_mass_erase,
  output logic [6:0] arr_page,
  // CPU and port status
  output logic cpu_halt,
  output logic port_done
);
  typedef struct packed {
    fpe_pkg::fpe_state_t st;
    fpe_pkg::fpe_op_t op;
    logic [7:0] page;
    logic [7:0] guard;
    logic by_port;
    logic mass_done;
    logic prog_any;
    logic prog_page;
    logic halt;
    logic done;
    logic aprog;
    logic [15:0] aaddr;
    logic [7:0] adata;
    logic ainfo;
    logic apage;
    logic amass;
    logic [7:0] stat;
    logic opt_q1;
    logic opt_q2;
  } fpe_st_t;
  fpe_st_t s_r, s_nxt;
  fpe_timer_if tif ();
  logic t_start;
  logic [15:0] t_cyc;
  logic page_hit;
  logic info_hit;
  logic cpu_prog_ok;
  logic port_prog_ok;
  logic erase_ok;
  logic [2:0] sect_idx;
  logic page_guarded;
  logic is_info;
  logic cmd_wr, page_wr;

  fpe_timer u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tif(tif)
  );
  assign tif.start = t_start;
  assign tif.cycles = t_cyc;

  assign sect_idx = s_r.page[6:`FPE_SECT_SHIFT]; // RULE_25 RULE_04
  assign page_guarded = s_r.guard[sect_idx]; // RULE_08
  assign is_info = s_r.page[`FPE_INFO_BIT]; // RULE_24
  assign cmd_wr = reg_wr && (reg_addr == `FPE_OFS_CMD);
  assign page_wr = reg_wr && (reg_addr == `FPE_OFS_PAGE);

  // Every main-memory byte must sit inside the selected page
  assign page_hit = prog_addr[`FPE_ADDR_PAGE_HI:`FPE_ADDR_PAGE_LO] == s_r.page[6:0]; // RULE_03
  assign info_hit = prog_addr[`FPE_INFO_ADDR_HI:`FPE_INFO_ADDR_LO] == s_r.page[6:0]; // RULE_24
  // CPU writes only where an earlier page or mass erase opened the way, until another command closes it
  assign cpu_prog_ok = !prog_from_port && !is_info && !page_guarded && page_hit &&
    (s_r.prog_any || s_r.prog_page); // RULE_08 RULE_10 RULE_11
  // Port ignores the guard and may reach information page 3
  assign port_prog_ok = prog_from_port && ((!is_info && page_hit) ||
    (s_r.page == `FPE_INFO_PAGE3 && info_hit)); // RULE_10 RULE_24
  // A refused page erase relocks, so the caller must unlock again
  assign erase_ok = (!is_info && (reg_from_port || !page_guarded)) ||
    (is_info && reg_from_port && s_r.page == `FPE_INFO_PAGE3 &&
    (!s_r.opt_q2 || s_r.mass_done)); // RULE_16 RULE_19 RULE_23

  always_comb
  begin
    s_nxt = s_r;
    t_start = 1'b0;
    t_cyc = `FPE_PROG_CYC;
    s_nxt.done = 1'b0;
    s_nxt.aprog = 1'b0;
    s_nxt.apage = 1'b0;
    s_nxt.amass = 1'b0;
    // Option pin is outside this clock domain: two flops before use
    s_nxt.opt_q1 = protect_opt;
    s_nxt.opt_q2 = s_r.opt_q1;
    unique case (s_r.st)
      fpe_pkg::FPE_LOCKED:
      begin
        if (page_wr)
        begin
          s_nxt.page = reg_wdata;
          s_nxt.st = fpe_pkg::FPE_UNL1; // RULE_01
        end
        else if (cmd_wr && reg_wdata == `FPE_CMD_SECT_EN)
          s_nxt.st = fpe_pkg::FPE_SECT; // RULE_06 RULE_05
      end
      fpe_pkg::FPE_SECT:
      begin
        if (page_wr)
        begin
          s_nxt.guard = s_r.guard | reg_wdata; // RULE_09 RULE_06
          s_nxt.st = fpe_pkg::FPE_LOCKED;
        end
        else if (cmd_wr)
          s_nxt.st = fpe_pkg::FPE_LOCKED;
      end
      fpe_pkg::FPE_UNL1:
      begin
        if (cmd_wr)
          s_nxt.st = (reg_wdata == `FPE_CMD_UNLOCK1) ? fpe_pkg::FPE_UNL2 : fpe_pkg::FPE_LOCKED;
        else if (page_wr)
          s_nxt.page = reg_wdata; // Restarts the sequence with a new page
      end
      fpe_pkg::FPE_UNL2:
      begin
        if (cmd_wr)
          s_nxt.st = (reg_wdata == `FPE_CMD_UNLOCK2) ? fpe_pkg::FPE_UNL3 : fpe_pkg::FPE_LOCKED;
        else if (page_wr)
          s_nxt.st = fpe_pkg::FPE_LOCKED; // RULE_01
      end
      fpe_pkg::FPE_UNL3:
      begin
        if (page_wr)
          s_nxt.st = (reg_wdata == s_r.page) ? fpe_pkg::FPE_OPEN : fpe_pkg::FPE_LOCKED; // RULE_01
        else if (cmd_wr)
          s_nxt.st = fpe_pkg::FPE_LOCKED;
      end
      fpe_pkg::FPE_OPEN:
      begin
        if (cmd_wr && reg_wdata == `FPE_CMD_PAGE_ERASE)
        begin
          // RULE_17 RULE_16 RULE_19 RULE_23
          if (erase_ok)
          begin
            s_nxt.st = fpe_pkg::FPE_BUSY;
            s_nxt.op = fpe_pkg::FPE_OP_PAGE;
            s_nxt.by_port = reg_from_port;
            s_nxt.halt = !reg_from_port; // RULE_14
            s_nxt.apage = 1'b1;
            s_nxt.ainfo = is_info;
            t_start = 1'b1;
            t_cyc = `FPE_ERASE_CYC;
          end
          else
            s_nxt.st = fpe_pkg::FPE_LOCKED;
        end
        else if (cmd_wr && reg_wdata == `FPE_CMD_MASS_ERASE)
        begin
          if (reg_from_port) // RULE_20 RULE_21
          begin
            s_nxt.st = fpe_pkg::FPE_BUSY;
            s_nxt.op = fpe_pkg::FPE_OP_MASS;
            s_nxt.by_port = 1'b1;
            s_nxt.amass = 1'b1;
            s_nxt.ainfo = 1'b0; // RULE_22
            t_start = 1'b1;
            t_cyc = `FPE_ERASE_CYC;
          end
          // CPU mass erase code is ignored and the controller stays open
        end
        else if (cmd_wr)
        begin
          s_nxt.st = fpe_pkg::FPE_LOCKED; // RULE_02 RULE_15
          s_nxt.prog_any = 1'b0;
          s_nxt.prog_page = 1'b0;
        end
        else if (page_wr && !reg_from_port)
          s_nxt.st = fpe_pkg::FPE_LOCKED; // CPU page write relocks
        else if (prog_req)
        begin
          // RULE_03 RULE_10 RULE_11 RULE_08 RULE_12 RULE_13
          // A refused byte is dropped without relocking
          if (cpu_prog_ok || port_prog_ok)
          begin
            s_nxt.st = fpe_pkg::FPE_BUSY;
            s_nxt.op = fpe_pkg::FPE_OP_PROG;
            s_nxt.by_port = prog_from_port;
            s_nxt.halt = !prog_from_port; // RULE_14
            s_nxt.aprog = 1'b1;
            s_nxt.aaddr = prog_addr;
            s_nxt.adata = prog_data & prog_old; // RULE_12
            s_nxt.ainfo = is_info;
            t_start = 1'b1;
          end
        end
      end
      fpe_pkg::FPE_BUSY:
      begin
        if (tif.done)
        begin
          s_nxt.halt = 1'b0; // RULE_14
          if (s_r.op == fpe_pkg::FPE_OP_PROG)
            s_nxt.st = fpe_pkg::FPE_OPEN; // Page stays open for more bytes
          else
          begin
            s_nxt.st = fpe_pkg::FPE_LOCKED; // RULE_18
            s_nxt.done = s_r.by_port; // RULE_18
            if (s_r.op == fpe_pkg::FPE_OP_MASS)
            begin
              s_nxt.mass_done = 1'b1; // RULE_23
              s_nxt.prog_any = 1'b1; // RULE_11
            end
            else
              s_nxt.prog_page = 1'b1; // RULE_11
          end
        end
      end
      default:
        s_nxt.st = fpe_pkg::FPE_LOCKED;
    endcase
    case (s_nxt.st)
      fpe_pkg::FPE_UNL2: s_nxt.stat = 8'h01;
      fpe_pkg::FPE_UNL3: s_nxt.stat = 8'h02;
      fpe_pkg::FPE_OPEN: s_nxt.stat = 8'h03;
      fpe_pkg::FPE_SECT: s_nxt.stat = 8'h04;
      fpe_pkg::FPE_BUSY:
        s_nxt.stat = (s_nxt.op == fpe_pkg::FPE_OP_PROG) ? 8'h08 :
                     (s_nxt.op == fpe_pkg::FPE_OP_PAGE) ? 8'h10 : 8'h20;
      default: s_nxt.stat = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.st <= fpe_pkg::FPE_LOCKED;
      s_r.guard <= `FPE_SECT_RESET; // RULE_07
      s_r.page <= `FPE_PAGE_RESET;
      // Treat the part as protected until the option pin has been seen
      s_r.opt_q1 <= `FPE_OPT_RESET;
      s_r.opt_q2 <= `FPE_OPT_RESET;
    end
    else
      s_r <= s_nxt;
  end

  assign status_rdata = s_r.stat;
  assign page_rdata = s_r.page;
  assign guard_rdata = s_r.guard;
  assign arr_prog = s_r.aprog;
  assign arr_addr = s_r.aaddr;
  assign arr_data = s_r.adata;
  assign arr_info = s_r.ainfo;
  assign arr_page_erase = s_r.apage;
  assign arr_mass_erase = s_r.amass;
  assign arr_page = s_r.page[6:0];
  assign cpu_halt = s_r.halt;
  assign port_done = s_r.done; // RULE_18
endmodule // fpe_flash_seq

// file: fpe_host_model.sv
`timescale 1ns/1ps
// Host model: CPU or in-circuit port issuing writes and byte programs
module fpe_host_model (
  // Clock
  input wire logic clk_sys,
  // Requests
  output logic reg_wr,
  output logic reg_from_port,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic prog_req,
  output logic prog_from_port,
  output logic [15:0] prog_addr,
  output logic [7:0] prog_data,
  output logic [7:0] prog_old
);
  initial
  begin
    {reg_wr, reg_from_port, reg_addr, reg_wdata} = 18'h00000;
    {prog_req, prog_from_port, prog_addr, prog_data, prog_old} = 34'h000000000;
  end
  // Released lines show inverted values so stale data never matches
  task automatic wr(input logic p, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    {reg_wr, reg_from_port, reg_addr, reg_wdata} = {1'h1, p, a, d};
    @(negedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} = {1'h0, ~a, ~d};
  endtask
  task automatic unlock(input logic p, input logic [7:0] pg);
    wr(p, 8'h02, pg);
    wr(p, 8'h01, 8'h73);
    wr(p, 8'h01, 8'h8c);
    wr(p, 8'h02, pg);
  endtask
  task automatic prog(input logic p, input logic [15:0] a, input logic [7:0] d, input logic [7:0] o);
    @(negedge clk_sys);
    {prog_req, prog_from_port, prog_addr, prog_data, prog_old} = {1'h1, p, a, d, o};
    @(negedge clk_sys);
    {prog_req, prog_addr, prog_data, prog_old} = {1'h0, ~a, ~d, ~o};
  endtask
endmodule // fpe_host_model

// file: fpe_flash_seq_props.sv
`timescale 1ns/1ps
// Concurrent checks on the flash sequencer ports
module fpe_flash_seq_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Requests
  input wire logic reg_wr,
  input wire logic reg_from_port,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] prog_data,
  input wire logic [7:0] prog_old,
  // Results
  input wire logic [7:0] status_rdata,
  input wire logic [7:0] page_rdata,
  input wire logic [7:0] guard_rdata,
  input wire logic arr_prog,
  input wire logic [15:0] arr_addr,
  input wire logic [7:0] arr_data,
  input wire logic arr_info,
  input wire logic arr_page_erase,
  input wire logic arr_mass_erase,
  input wire logic port_done
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_cmdw;
    reg_wr && reg_addr == 8'h01;
  endsequence
  sequence s_open;
    status_rdata == 8'h03;
  endsequence
  a_relock_on_other: assert property (s_open ##0 s_cmdw ##0
    (reg_wdata != 8'h95 && reg_wdata != 8'h63) |=> status_rdata == 8'h00)
    else $error("no relock after other command");
  a_port_page_start: assert property (s_open ##0 s_cmdw ##0
    (reg_wdata == 8'h95 && reg_from_port && !page_rdata[7]) |=> arr_page_erase)
    else $error("port page erase not started");
  a_cpu_mass_drop: assert property (s_open ##0 s_cmdw ##0
    (reg_wdata == 8'h63 && !reg_from_port) |=> !arr_mass_erase && status_rdata == 8'h03)
    else $error("cpu mass erase not ignored");
  a_guard_set_only: assert property ($past(rst_n) |->
    ($past(guard_rdata) & ~guard_rdata) == 8'h00)
    else $error("guard bit cleared");
  a_guard_when_sel: assert property ($past(rst_n) && $changed(guard_rdata) |->
    $past(status_rdata) == 8'h04)
    else $error("guard written outside select");
  a_prog_in_page: assert property (arr_prog |-> arr_info ||
    arr_addr[15:9] == page_rdata[6:0])
    else $error("program outside page");
  a_prog_clears_bits: assert property (arr_prog |->
    arr_data == ($past(prog_data) & $past(prog_old)))
    else $error("program set a bit");
  a_done_relocks: assert property (port_done |-> ##[0:1] status_rdata == 8'h00)
    else $error("no relock after erase");
endmodule // fpe_flash_seq_props
bind fpe_flash_seq fpe_flash_seq_props chk_u (.clk_sys, .rst_n, .reg_wr, .reg_from_port,
  .reg_addr, .reg_wdata, .prog_data, .prog_old, .status_rdata, .page_rdata, .guard_rdata,
  .arr_prog, .arr_addr, .arr_data, .arr_info, .arr_page_erase, .arr_mass_erase, .port_done);

// file: tb.sv
`timescale 1ns/1ps
// Self-checking bench for the flash sequencer
module tb;
  localparam logic C = 1'h0;
  localparam logic P = 1'h1;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic reg_wr, reg_from_port, prog_req, prog_from_port;
  logic [7:0] reg_addr, reg_wdata, prog_data, prog_old, status_rdata, page_rdata;
  logic [7:0] guard_rdata, arr_data, pr_data;
  logic [15:0] prog_addr, arr_addr, pr_addr;
  logic [6:0] arr_page, pe_page;
  logic arr_prog, arr_info, arr_page_erase, arr_mass_erase, cpu_halt, port_done;
  logic pe, me, pr, ht, dn, inf;
  logic protect_opt = 1'h1;
  int bad_count = 0;
  int check_count = 0;
  always #12.5 clk_sys = ~clk_sys;
  fpe_host_model host_u (.clk_sys, .reg_wr, .reg_from_port, .reg_addr, .reg_wdata, .prog_req,
    .prog_from_port, .prog_addr, .prog_data, .prog_old);
  // Option mostly set so an info-page erase needs a prior mass erase
  fpe_flash_seq dut_u (.clk_sys, .rst_n, .reg_wr, .reg_from_port, .reg_addr, .reg_wdata,
    .status_rdata, .page_rdata, .guard_rdata, .prog_req, .prog_from_port, .prog_addr,
    .prog_data, .prog_old, .protect_opt, .arr_prog, .arr_addr, .arr_data, .arr_info,
    .arr_page_erase, .arr_mass_erase, .arr_page, .cpu_halt, .port_done);
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude;
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Pulses last one cycle, so sample every cycle and keep what was seen
  task automatic watch(input int n);
    {pe, me, pr, ht, dn, inf} = 6'h00;
    repeat (n)
    begin
      if (arr_page_erase)
        pe_page = arr_page;
      if (arr_prog)
      begin
        pr_data = arr_data;
        pr_addr = arr_addr;
      end
      if (arr_page_erase || arr_mass_erase || arr_prog)
        inf = arr_info;
      {pe, me, pr, ht, dn} = {pe, me, pr, ht, dn} |
        {arr_page_erase, arr_mass_erase, arr_prog, cpu_halt, port_done};
      @(negedge clk_sys);
    end
  endtask
  task automatic run(input logic p, input logic [7:0] pg, input logic [7:0] cmd);
    host_u.unlock(p, pg);
    host_u.wr(p, 8'h01, cmd);
    watch(30);
  endtask
  task automatic t_unlock;
    check("guard rst", guard_rdata, 8'h00);
    host_u.unlock(C, 8'h05);
    check("open", status_rdata, 8'h03);
    host_u.wr(C, 8'h01, 8'h11);
    check("relock", status_rdata, 8'h00);
    host_u.wr(C, 8'h02, 8'h05);
    host_u.wr(C, 8'h01, 8'h73);
    host_u.wr(C, 8'h01, 8'h8c);
    host_u.wr(C, 8'h02, 8'h06);
    check("bad seq", status_rdata, 8'h00);
  endtask
  task automatic t_erase;
    run(P, 8'h83, 8'h95);
    check("info early", pe, 1'h0);
    protect_opt = 1'h0;
    run(P, 8'h83, 8'h95);
    check("info open", {pe, inf, dn}, 3'h7);
    protect_opt = 1'h1;
    run(P, 8'h05, 8'h95);
    check("page", {pe, dn, pe_page}, {2'h3, 7'h05});
    check("relock", status_rdata, 8'h00);
    run(C, 8'h05, 8'h63);
    check("cpu mass", {me, status_rdata}, {1'h0, 8'h03});
    host_u.wr(C, 8'h01, 8'h00);
    run(P, 8'h05, 8'h63);
    check("mass", {me, dn, inf, status_rdata}, {3'h6, 8'h00});
    run(P, 8'h83, 8'h95);
    check("info late", {pe, inf, pe_page}, {2'h3, 7'h03});
    run(C, 8'h83, 8'h95);
    check("info cpu", {pe, status_rdata}, {1'h0, 8'h00});
  endtask
  task automatic t_guard;
    host_u.wr(C, 8'h01, 8'h5e);
    check("sel", status_rdata, 8'h04);
    host_u.wr(C, 8'h02, 8'h01);
    check("guard", {guard_rdata, page_rdata}, {8'h01, 8'h83});
    host_u.wr(C, 8'h01, 8'h5e);
    host_u.wr(C, 8'h02, 8'h00);
    check("sticky", guard_rdata, 8'h01);
    run(C, 8'h0f, 8'h95);
    check("guarded", {pe, status_rdata}, {1'h0, 8'h00});
    run(P, 8'h0f, 8'h95);
    check("port", pe, 1'h1);
    run(C, 8'h10, 8'h95);
    check("cpu erase", {pe, ht, dn, pe_page}, {3'h6, 7'h10});
  endtask
  task automatic t_prog;
    host_u.unlock(C, 8'h10);
    host_u.prog(C, {7'h10, 9'h005}, 8'ha5, 8'hf0);
    watch(8);
    check("prog", {pr, ht, pr_data}, {2'h3, 8'ha0});
    check("prog addr", pr_addr, {7'h10, 9'h005});
    check("resume", cpu_halt, 1'h0);
    host_u.prog(C, {7'h11, 9'h005}, 8'ha5, 8'hff);
    watch(8);
    check("other page", pr, 1'h0);
    host_u.wr(C, 8'h01, 8'h00);
    check("end", status_rdata, 8'h00);
    host_u.unlock(P, 8'h83);
    host_u.prog(P, 16'h00c5, 8'h3c, 8'hff);
    watch(8);
    check("info prog", {pr, inf, ht, pr_data}, {3'h6, 8'h3c});
    check("info addr", pr_addr, 16'h00c5);
    host_u.wr(P, 8'h01, 8'h00);
    check("port end", status_rdata, 8'h00);
  endtask
  task automatic t_reset;
    rst_n = 1'h0;
    repeat (4) @(negedge clk_sys);
    rst_n = 1'h1;
    check("rst", {guard_rdata, status_rdata}, 16'h0000);
    run(P, 8'h83, 8'h95);
    check("info cycle", {pe, status_rdata}, {1'h0, 8'h00});
  endtask
  // Whole sequence needs about 540 cycles; allow about six times that
  initial
  begin
    #80us;
    bad_count++;
    conclude();
  end
  initial
  begin
    repeat (16) @(negedge clk_sys);
    rst_n = 1'h1;
    t_unlock();
    t_erase();
    t_guard();
    t_prog();
    t_reset();
    conclude();
  end
endmodule // tb
